// [inc/trip_relay_defs.vh]
// Constants for the trip relay command logic
`ifndef TRIP_RELAY_DEFS_VH
`define TRIP_RELAY_DEFS_VH
`define CLK_FREQ_HZ 40000000
`define SAMPLE_PERIOD_US 1000
`define PREP_TIMEOUT_MS 50
`define USER_LAT_MIN_MS 2
`define USER_LAT_MAX_MS 4
`define CYCLES_PER_SAMPLE ((`CLK_FREQ_HZ / 1000000) * `SAMPLE_PERIOD_US)
`define NUM_CONTACTS 4
`define NUM_PHASES 3
`define STRETCH_DEFAULT_MS 8'h64
`endif

// [rtl/trip_stretch.v]
// Minimum on-time stretcher for one aligned trip line
`timescale 1ns/1ps
`include "trip_relay_defs.vh"
module trip_stretch #(
	parameter CW = 16
) (
	clk,
	nrst,
	tick,
	req,
	min_ticks,
	out
);
	input wire clk;
	input wire nrst;
	input wire tick;
	input wire req;
	input wire [CW-1:0] min_ticks;
	output reg out;

	reg [CW-1:0] cnt_q;

	// Restart on every request tick; hold until count runs out
	always @(posedge clk) begin
		if (!nrst) begin
			cnt_q <= {CW{1'b0}};
			out <= 1'b0;
		end else if (tick) begin
			if (req) begin
				cnt_q <= min_ticks;
				out <= 1'b1;
			end else if (cnt_q > {{(CW-1){1'b0}}, 1'b1}) begin
				cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
				out <= 1'b1;
			end else begin
				cnt_q <= {CW{1'b0}};
				out <= 1'b0;
			end
		end
	end
endmodule // trip_stretch

// [rtl/trip_relay_command_logic.v]
// Two-step trip contact command logic with fast, single-cycle and user sources
`timescale 1ns/1ps
`include "trip_relay_defs.vh"
module trip_relay_command_logic #(
	parameter NC = `NUM_CONTACTS,
	parameter SAMPLE_CYCLES = `CYCLES_PER_SAMPLE,
	parameter PREP_TICKS = `PREP_TIMEOUT_MS,
	parameter USER_DELAY_TICKS = `USER_LAT_MIN_MS,
	parameter SCW = 16
) (
	clk,
	nrst,
	prot_pickup,
	prot_trip,
	phase_trip,
	ph2ph_fault,
	align_3ph_en,
	stretch_ticks,
	align_assign,
	fast_sig,
	single_cycle_en_n,
	user_sig,
	mech_contact,
	fast_switch,
	contact_out,
	prep_active,
	sample_tick
);
	input wire clk;
	input wire nrst;
	input wire [NC-1:0] prot_pickup;
	input wire [NC-1:0] prot_trip;
	input wire [`NUM_PHASES-1:0] phase_trip;
	input wire ph2ph_fault;
	input wire align_3ph_en;
	input wire [SCW-1:0] stretch_ticks;
	input wire [NC*`NUM_PHASES-1:0] align_assign;
	input wire [NC-1:0] fast_sig;
	input wire [NC-1:0] single_cycle_en_n;
	input wire [NC-1:0] user_sig;
	output reg [NC-1:0] mech_contact;
	output reg [NC-1:0] fast_switch;
	output reg [NC-1:0] contact_out;
	output reg [NC-1:0] prep_active;
	output reg sample_tick;

	localparam ST_IDLE = 3'b001;
	localparam ST_PREP = 3'b010;
	localparam ST_TRIP = 3'b100;

	reg [31:0] div_q;
	reg [NC-1:0] fast_q;
	reg [NC-1:0] user_pipe_q [0:USER_DELAY_TICKS];
	wire [`NUM_PHASES-1:0] phase_req;
	wire [`NUM_PHASES-1:0] phase_str;
	reg [NC-1:0] align_or;
	integer k;
	integer j;
	genvar g;

	// OR of assigned phase lines for one contact
	function align_pick;
		input [`NUM_PHASES-1:0] ph;
		input [`NUM_PHASES-1:0] msk;
		begin
			align_pick = |(ph & msk);
		end
	endfunction

	// Sampling cycle tick: the fast path updates once per period
	always @(posedge clk) begin
		if (!nrst) begin
			div_q <= 32'h00000000;
			sample_tick <= 1'b0;
		end else if (div_q >= SAMPLE_CYCLES - 1) begin
			div_q <= 32'h00000000;
			sample_tick <= 1'b1;
		end else begin
			div_q <= div_q + 32'h00000001;
			sample_tick <= 1'b0;
		end
	end

	// With align_3ph_en set, a phase-to-phase fault widens any phase request to all three
	assign phase_req = (align_3ph_en && ph2ph_fault && (|phase_trip)) ?
		{`NUM_PHASES{1'b1}} : phase_trip;

	generate
		for (g = 0; g < `NUM_PHASES; g = g + 1) begin : g_str
			trip_stretch #(
				.CW(SCW)
			) u_str (
				.clk(clk),
				.nrst(nrst),
				.tick(sample_tick),
				.req(phase_req[g]),
				.min_ticks(stretch_ticks),
				.out(phase_str[g])
			);
		end
	endgenerate

	always @* begin
		for (j = 0; j < NC; j = j + 1) begin
			align_or[j] = align_pick(phase_str,
				align_assign[j*`NUM_PHASES +: `NUM_PHASES]);
		end
	end

	// Per-contact two-step preparation state
	generate
		for (g = 0; g < NC; g = g + 1) begin : g_ch
			reg [2:0] st_q;
			reg [15:0] tmo_q;
			always @(posedge clk) begin
				if (!nrst) begin
					st_q <= ST_IDLE;
					tmo_q <= 16'h0000;
				end else if (sample_tick) begin
					case (st_q)
						ST_IDLE: begin
							tmo_q <= 16'h0000;
							if (prot_trip[g])
								st_q <= ST_TRIP;
							else if (prot_pickup[g])
								st_q <= ST_PREP;
						end
						ST_PREP: begin
							if (prot_trip[g]) begin
								st_q <= ST_TRIP;
							end else if (tmo_q >= PREP_TICKS - 1) begin
								st_q <= ST_IDLE;
								tmo_q <= 16'h0000;
							end else begin
								tmo_q <= tmo_q + 16'h0001;
							end
						end
						ST_TRIP: begin
							if (!prot_trip[g])
								st_q <= prot_pickup[g] ? ST_PREP : ST_IDLE;
							tmo_q <= 16'h0000;
						end
						default: st_q <= ST_IDLE;
					endcase
				end
			end
			always @(posedge clk) begin
				if (!nrst) begin
					mech_contact[g] <= 1'b0;
					fast_switch[g] <= 1'b0;
					prep_active[g] <= 1'b0;
				end else begin
					mech_contact[g] <= (st_q != ST_IDLE);
					fast_switch[g] <= (st_q == ST_TRIP);
					prep_active[g] <= (st_q == ST_PREP);
				end
			end
		end
	endgenerate

	// Single-cycle signals sampled each tick, no preparation; default on
	always @(posedge clk) begin
		if (!nrst)
			fast_q <= {NC{1'b0}};
		else if (sample_tick)
			fast_q <= fast_sig & ~single_cycle_en_n;
	end

	// User logic is slower: delayed by whole sample periods, direct drive
	always @(posedge clk) begin
		if (!nrst) begin
			for (k = 0; k <= USER_DELAY_TICKS; k = k + 1)
				user_pipe_q[k] <= {NC{1'b0}};
		end else if (sample_tick) begin
			user_pipe_q[0] <= user_sig;
			for (k = 1; k <= USER_DELAY_TICKS; k = k + 1)
				user_pipe_q[k] <= user_pipe_q[k-1];
		end
	end

	// Breaker energised when series pair closed or any other source on
	always @(posedge clk) begin
		if (!nrst)
			contact_out <= {NC{1'b0}};
		else
			contact_out <= (mech_contact & fast_switch) | align_or | fast_q |
				user_pipe_q[USER_DELAY_TICKS];
	end
endmodule // trip_relay_command_logic

// [verification/trip_relay_properties.sv]
// Port-level timing checks for the trip relay command logic
`timescale 1ns/1ps
module trip_relay_checker #(parameter NC = 4) (
	input wire clk,
	input wire nrst,
	input wire [NC-1:0] prot_pickup,
	input wire [NC-1:0] prot_trip,
	input wire [NC-1:0] fast_sig,
	input wire [NC-1:0] single_cycle_en_n,
	input wire [NC-1:0] mech_contact,
	input wire [NC-1:0] fast_switch,
	input wire [NC-1:0] contact_out,
	input wire [NC-1:0] prep_active,
	input wire sample_tick
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_tick_spacing: assert property (sample_tick |=> !sample_tick [*8])
		else $error("sample tick too close");
	a_switch_series: assert property (fast_switch[0] |-> mech_contact[0])
		else $error("fast switch closed without contact");
	a_prep_state: assert property (prep_active[0] |-> mech_contact[0] && !fast_switch[0])
		else $error("preparation state wrong");
	a_pickup_prepares: assert property (sample_tick && prot_pickup[0] && !prot_trip[0]
		&& !mech_contact[0] |-> ##2 mech_contact[0] && prep_active[0])
		else $error("pickup did not prepare");
	a_trip_energises: assert property (mech_contact[0] && $rose(fast_switch[0])
		|=> contact_out[0])
		else $error("trip did not energise");
	a_prep_timeout: assert property ($rose(prep_active[0]) |-> ##[1:520] !prep_active[0])
		else $error("preparation never withdrawn");
	a_fast_on_tick: assert property (!$stable(mech_contact) |-> $past(sample_tick, 2))
		else $error("contact moved off tick");
	a_single_cycle: assert property (sample_tick && fast_sig[0] && !single_cycle_en_n[0]
		|-> ##[1:2] contact_out[0])
		else $error("single cycle contact late");
	a_reset_clear: assert property (disable iff (1'b0) !nrst |=> contact_out == 0
		&& mech_contact == 0 && fast_switch == 0)
		else $error("outputs not cleared");
endmodule // trip_relay_checker

bind trip_relay_command_logic trip_relay_checker #(.NC(NC)) i_chk (.clk(clk), .nrst(nrst),
	.prot_pickup(prot_pickup), .prot_trip(prot_trip), .fast_sig(fast_sig),
	.single_cycle_en_n(single_cycle_en_n), .mech_contact(mech_contact),
	.fast_switch(fast_switch), .contact_out(contact_out), .prep_active(prep_active),
	.sample_tick(sample_tick));

// [verification/breaker_coil.sv]
// Breaker trip coil model counting energisations
`timescale 1ns/1ps
module breaker_coil (
	input wire clk,
	input wire coil,
	output reg [7:0] trips = 8'h00
);
	reg was_q = 1'b0;
	// Only a fresh energisation trips; a held coil counts once
	always @(posedge clk) begin
		if (coil && !was_q) trips <= trips + 8'h01;
		was_q <= coil;
	end
endmodule // breaker_coil

// [verification/test_trip_relay_command_logic.sv]
// Self-checking bench for the trip relay command logic
`timescale 1ns/1ps
module test_trip_relay_command_logic;
	reg clk = 0, nrst = 0, ph2 = 1, en3 = 1;
	reg [3:0] pk = 0, tr = 0, fs = 0, en = 0, us = 0;
	reg [2:0] ph = 0;
	reg [15:0] st = 16'h0005;
	reg [11:0] asg = 12'h800;
	wire [3:0] mc, fw, co, pa;
	wire tk;
	wire [7:0] trips;
	integer err_count = 0, n_tests = 0, cyc = 0, seen;
	always #12.5 clk = ~clk;
	trip_relay_command_logic #(.SAMPLE_CYCLES(10)) i_dut (.clk(clk), .nrst(nrst),
		.prot_pickup(pk), .prot_trip(tr), .phase_trip(ph), .ph2ph_fault(ph2),
		.align_3ph_en(en3), .stretch_ticks(st), .align_assign(asg), .fast_sig(fs),
		.single_cycle_en_n(en), .user_sig(us), .mech_contact(mc), .fast_switch(fw),
		.contact_out(co), .prep_active(pa), .sample_tick(tk));
	breaker_coil i_coil (.clk(clk), .coil(co[0]), .trips(trips));
	task report_and_stop;
	begin
		$display("errors %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	end
	endtask
	task chk(input [3:0] got, input [3:0] exp);
	begin
		n_tests = n_tests + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	end
	endtask
	// Wait n evaluation ticks, then let the registered outputs settle
	task ticks(input integer n);
	begin
		repeat (n) begin
			@(posedge clk);
			while (!tk) @(posedge clk);
		end
		repeat (3) @(posedge clk);
		#1;
	end
	endtask
	// Reference: protection path, gated single-cycle path and user path ORed
	function [3:0] model(input integer p, t, f, e, u);
		model = p & t | f & ~e | u;
	endfunction
	// Hang guard; the full sequence needs about 800 cycles
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			err_count = err_count + 1;
			report_and_stop;
		end
	end
	initial begin
		seen = $urandom(32'hEC078E4D);
		repeat (20) @(posedge clk);
		#1 nrst = 1;
		pk = 4'h1;
		ticks(1);
		chk(mc & pa, 4'h1);
		chk(co, 4'h0);
		ticks(48);
		chk(mc, 4'h1);
		seen = 0;
		repeat (40) @(posedge clk) seen = seen | !pa[0];
		chk(seen, 4'h1);
		tr = 4'h1;
		ticks(1);
		chk(fw & mc, 4'h1);
		chk(co, model(pk, tr, 0, 0, 0));
		pk = 0;
		tr = 0;
		ticks(1);
		chk(co | fw, 4'h0);
		chk(trips[3:0], 4'h1);
		fs = 4'h5;
		ticks(1);
		chk(co, 4'h5);
		repeat (4) begin
			fs = $urandom;
			en = $urandom;
			ticks(1);
			chk(co, model(0, 0, fs, en, 0));
		end
		fs = 0;
		us = 4'hF;
		ticks(1);
		chk(co, 4'h0);
		ticks(3);
		chk(co, model(0, 0, 0, 0, us));
		us = 0;
		ticks(4);
		chk(co, 4'h0);
		ph = 3'h1;
		ticks(1);
		ph = 0;
		chk(co, 4'h8);
		ticks(2);
		chk(co, 4'h8);
		ticks(5);
		chk(co, 4'h0);
		report_and_stop;
	end
endmodule // test_trip_relay_command_logic
